// >>> hw/sw_time_pkg.sv
package sw_time_pkg;
  localparam int NUM_OUT = 4;
  localparam int CFG_W = 56;
  localparam int PIN_CFG_W = 32;
  // Parameter indices: pin settings records and time-module records
  localparam logic [7:0] IDX_PIN_CFG_BASE = 8'h50;
  localparam logic [7:0] IDX_TIME_CFG_BASE = 8'h54;
  localparam logic [7:0] IDX_PIN2_TIME_CFG = 8'h54;
  localparam logic [7:0] IDX_PIN7_TIME_CFG = 8'h57;
  // Time-module record layout
  localparam int MODE_LSB = 48;
  localparam int TCONST_LSB = 32;
  localparam int MASK_LSB = 0;
  // Pin settings record layout
  localparam int IOSEL_LSB = 24;
  localparam int BEHAV_LSB = 16;
  localparam int OFUNC_LSB = 0;
  localparam logic [7:0] IOSEL_OUTPUT = 8'h00;
  localparam logic [7:0] IOSEL_MAX = 8'h01;
  localparam logic [7:0] BEHAV_INVERTED = 8'h01;
  localparam logic [7:0] BEHAV_MAX = 8'h01;
  localparam logic [7:0] OFUNC_SWITCHING = 8'h01;
  localparam logic [7:0] OFUNC_MAX = 8'h03;
  localparam logic [7:0] INFUNC_MAX = 8'h02;
  localparam int INFUNC_LSB = 8;
  // Limits and reset values
  localparam logic [15:0] TCONST_MAX = 16'hFDE8;
  localparam logic [31:0] MASK_RST = 32'h00000001;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [63:0] TCONST_RST = {16'h0008, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [31:0] PIN_CFG_RST = 32'h00000000;
  // Millisecond time base from the 20 MHz device clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [7:0] {
    MODE_OFF = 8'h00,
    MODE_STARTUP_DELAY = 8'h01,
    MODE_SWITCHOFF_DELAY = 8'h02,
    MODE_PULSE_STRETCH = 8'h03,
    MODE_PULSE_SUPPRESS = 8'h04
  } tm_mode_t;
endpackage

// >>> hw/time_function.sv
module time_function (
  input wire logic ref_clk, // Device clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic ms_tick, // One-cycle pulse each millisecond
  input wire logic [7:0] mode, // Time-module mode
  input wire logic [15:0] tconst, // Time constant in ms
  input wire logic in_act, // Combined area state
  output logic out_r // Time-function result
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic out_nxt;
  logic expired;
  logic cnt_inc;
  logic [15:0] cnt_step;

  // A 0 ms constant expires at once, so the function turns transparent
  assign expired = (cnt_r >= tconst);
  assign cnt_inc = ms_tick && (cnt_r != 16'hFFFF);
  assign cnt_step = cnt_inc ? cnt_r + 16'h0001 : cnt_r;

  always_comb begin
    cnt_nxt = 16'h0000;
    out_nxt = in_act;
    case (mode)
      sw_time_pkg::MODE_STARTUP_DELAY, sw_time_pkg::MODE_PULSE_SUPPRESS: begin
        // Activation only after the input held for the constant
        cnt_nxt = in_act ? cnt_step : 16'h0000;
        out_nxt = in_act && expired;
      end
      sw_time_pkg::MODE_SWITCHOFF_DELAY: begin
        // Deactivation extended by the constant after input drops
        cnt_nxt = in_act ? 16'h0000 : cnt_step;
        out_nxt = in_act || (out_r && !expired);
      end
      sw_time_pkg::MODE_PULSE_STRETCH: begin
        // Minimum active width counted from the rising edge
        if (in_act && !out_r) begin
          cnt_nxt = 16'h0000;
          out_nxt = 1'b1;
        end else if (out_r) begin
          cnt_nxt = cnt_step;
          out_nxt = in_act || !expired;
        end else begin
          cnt_nxt = 16'h0000;
          out_nxt = 1'b0;
        end
      end
      default: begin
        cnt_nxt = 16'h0000;
        out_nxt = in_act;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= 16'h0000;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end
endmodule

// >>> hw/switching_output_time_module.sv
module switching_output_time_module #(
  parameter int TICK_CYCLES = sw_time_pkg::TICK_CYCLES
) (
  input wire logic ref_clk, // Device clock, 20 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [31:0] area_state, // Beam area states 1..32, same clock
  input wire logic wr_en, // Parameter write strobe
  input wire logic [7:0] wr_index, // Parameter index written
  input wire logic [55:0] wr_data, // Parameter record written
  input wire logic rd_en, // Parameter read strobe
  input wire logic [7:0] rd_index, // Parameter index read
  output logic [55:0] rd_data_r, // Record read back
  output logic rd_ok_r, // Read hit a mapped index
  output logic wr_err_r, // Write refused: unmapped or out of range
  output logic [3:0] sw_out_r, // Switching output level, pins 2,5,6,7
  output logic [3:0] sw_drive_r, // Pin driven as beam-area switching output
  output logic [3:0] tm_state_r // Raw time-function results
);
  localparam int N = sw_time_pkg::NUM_OUT;

  logic [15:0] tick_cnt_r;
  logic ms_tick_r;
  logic tick_wrap;
  logic [15:0] tick_cnt_nxt;

  logic wr_time_hit;
  logic wr_pin_hit;
  logic [1:0] wr_slot;
  logic [7:0] wr_mode;
  logic [15:0] wr_tconst;
  logic [7:0] wr_iosel;
  logic [7:0] wr_behav;
  logic [7:0] wr_infunc;
  logic [7:0] wr_ofunc;
  logic wr_time_ok;
  logic wr_pin_ok;
  logic wr_err_nxt;
  logic wr_ok;
  logic wr_mode_ok;
  logic wr_tconst_ok;
  logic wr_iosel_ok;
  logic wr_behav_ok;
  logic wr_infunc_ok;
  logic wr_ofunc_ok;

  logic rd_time_hit;
  logic rd_pin_hit;
  logic [1:0] rd_slot;
  logic [55:0] rd_data_nxt;
  logic rd_hit;
  logic [55:0] rd_time_word;
  logic [55:0] rd_pin_word;

  logic [7:0] mode_r [N];
  logic [15:0] tconst_r [N];
  logic [31:0] mask_r [N];
  logic [31:0] pin_cfg_r [N];
  logic [N-1:0] tm_out;
  logic [N-1:0] pin_active;
  logic [N-1:0] pin_level;
  logic [N-1:0] pin_is_output;
  logic [N-1:0] pin_is_switching;
  logic [N-1:0] pin_inverted;
  logic [55:0] time_rec [N];
  logic [55:0] pin_rec [N];

  // Millisecond time base; a parameter so simulation can shorten it
  assign tick_wrap = (tick_cnt_r == 16'(TICK_CYCLES - 1));
  // The tick runs free, so a delay may end up to one tick early
  assign tick_cnt_nxt = tick_wrap ? 16'h0000 : tick_cnt_r + 16'h0001;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      ms_tick_r <= tick_wrap;
    end
  end

  // Write decode: time records at 0x54..0x57, pin settings at 0x50..0x53
  assign wr_time_hit = (wr_index[7:2] == sw_time_pkg::IDX_TIME_CFG_BASE[7:2]);
  assign wr_pin_hit = (wr_index[7:2] == sw_time_pkg::IDX_PIN_CFG_BASE[7:2]);
  assign wr_slot = wr_index[1:0];
  assign wr_mode = wr_data[sw_time_pkg::MODE_LSB +: 8];
  assign wr_tconst = wr_data[sw_time_pkg::TCONST_LSB +: 16];
  assign wr_iosel = wr_data[sw_time_pkg::IOSEL_LSB +: 8];
  assign wr_behav = wr_data[sw_time_pkg::BEHAV_LSB +: 8];
  assign wr_infunc = wr_data[sw_time_pkg::INFUNC_LSB +: 8];
  assign wr_ofunc = wr_data[sw_time_pkg::OFUNC_LSB +: 8];

  // Each field is range-checked alone so a refusal is easy to trace
  assign wr_mode_ok = (wr_mode <= sw_time_pkg::MODE_PULSE_SUPPRESS);
  assign wr_tconst_ok = (wr_tconst <= sw_time_pkg::TCONST_MAX);
  assign wr_iosel_ok = (wr_iosel <= sw_time_pkg::IOSEL_MAX);
  assign wr_behav_ok = (wr_behav <= sw_time_pkg::BEHAV_MAX);
  assign wr_infunc_ok = (wr_infunc <= sw_time_pkg::INFUNC_MAX);
  assign wr_ofunc_ok = (wr_ofunc <= sw_time_pkg::OFUNC_MAX);

  // Records are taken whole; an out-of-range field refuses the whole record
  assign wr_time_ok = wr_mode_ok && wr_tconst_ok;
  assign wr_pin_ok = wr_iosel_ok && wr_behav_ok && wr_infunc_ok && wr_ofunc_ok;
  // A refused or unmapped write leaves every record untouched
  assign wr_ok = (wr_time_hit && wr_time_ok) || (wr_pin_hit && wr_pin_ok);
  assign wr_err_nxt = wr_en && !wr_ok;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_err_r <= 1'b0;
    end else begin
      wr_err_r <= wr_err_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_out
      logic wr_time_sel;
      logic wr_pin_sel;
      logic area_sel;

      // One record pair and one time function per output pin
      assign wr_time_sel = wr_en && wr_time_hit && wr_time_ok && (wr_slot == 2'(g));
      assign wr_pin_sel = wr_en && wr_pin_hit && wr_pin_ok && (wr_slot == 2'(g));

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          mode_r[g] <= sw_time_pkg::MODE_RST;
          tconst_r[g] <= sw_time_pkg::TCONST_RST[16*g +: 16];
          mask_r[g] <= sw_time_pkg::MASK_RST;
          pin_cfg_r[g] <= sw_time_pkg::PIN_CFG_RST;
        end else begin
          if (wr_time_sel) begin
            mode_r[g] <= wr_mode;
            tconst_r[g] <= wr_tconst;
            mask_r[g] <= wr_data[sw_time_pkg::MASK_LSB +: 32];
          end
          if (wr_pin_sel) begin
            pin_cfg_r[g] <= wr_data[31:0];
          end
        end
      end

      // Selected areas are OR-combined; an empty mask never activates
      assign area_sel = |(area_state & mask_r[g]);

      // Each output owns its counter, so delays never interact
      time_function u_tf (
        .ref_clk(ref_clk),
        .rst(rst),
        .ms_tick(ms_tick_r),
        .mode(mode_r[g]),
        .tconst(tconst_r[g]),
        .in_act(area_sel),
        .out_r(tm_out[g])
      );

      assign pin_is_output[g] =
        (pin_cfg_r[g][sw_time_pkg::IOSEL_LSB +: 8] == sw_time_pkg::IOSEL_OUTPUT);
      assign pin_is_switching[g] =
        (pin_cfg_r[g][sw_time_pkg::OFUNC_LSB +: 8] == sw_time_pkg::OFUNC_SWITCHING);
      assign pin_inverted[g] =
        (pin_cfg_r[g][sw_time_pkg::BEHAV_LSB +: 8] == sw_time_pkg::BEHAV_INVERTED);

      // Only an output pin set to beam-area switching carries the result
      assign pin_active[g] = pin_is_output[g] && pin_is_switching[g];
      // Dark switching inverts the active sense
      assign pin_level[g] = pin_active[g] && (tm_out[g] ^ pin_inverted[g]);

      // Read-back images of both records of this output
      assign time_rec[g] = {mode_r[g], tconst_r[g], mask_r[g]};
      assign pin_rec[g] = {24'h000000, pin_cfg_r[g]};
    end
  endgenerate

  // Level and drive flag leave in one cycle so they never disagree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sw_out_r <= 4'h0;
      sw_drive_r <= 4'h0;
    end else begin
      sw_out_r <= pin_level;
      sw_drive_r <= pin_active;
    end
  end

  // Raw results ahead of polarity and routing, for diagnosis
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tm_state_r <= 4'h0;
    end else begin
      tm_state_r <= tm_out;
    end
  end

  // Read decode; unmapped indices answer zero with rd_ok low
  assign rd_time_hit = (rd_index[7:2] == sw_time_pkg::IDX_TIME_CFG_BASE[7:2]);
  assign rd_pin_hit = (rd_index[7:2] == sw_time_pkg::IDX_PIN_CFG_BASE[7:2]);
  assign rd_slot = rd_index[1:0];
  assign rd_hit = rd_time_hit || rd_pin_hit;
  assign rd_time_word = time_rec[rd_slot];
  assign rd_pin_word = pin_rec[rd_slot];
  assign rd_data_nxt = rd_time_hit ? rd_time_word :
    (rd_pin_hit ? rd_pin_word : 56'h00000000000000);

  // Hit flag is a one-cycle answer to each strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_ok_r <= 1'b0;
    end else begin
      rd_ok_r <= rd_en && rd_hit;
    end
  end

  // Data holds between strobes, so the reader may fetch it late
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_r <= 56'h00000000000000;
    end else if (rd_en) begin
      rd_data_r <= rd_data_nxt;
    end
  end
endmodule

// >>> testbench/sw_time_chk.sv
module sw_time_chk (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic wr_en, // Write
  input wire logic [7:0] wr_index, // Index
  input wire logic [55:0] wr_data, // Record
  input wire logic rd_en, // Read
  input wire logic [7:0] rd_index, // Index
  input wire logic rd_ok_r, // Hit
  input wire logic wr_err_r, // Refused
  input wire logic [3:0] sw_out_r, // Levels
  input wire logic [3:0] sw_drive_r, // Driven
  input wire logic [3:0] tm_state_r // Raw
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire tw = wr_en && wr_index[7:2] == 6'h15;
  wire pw = wr_en && wr_index == 8'h50 && wr_data[31:0] == 32'h0001_0001;
  wire [7:0] md = wr_data[55:48];
  wire [15:0] tc = wr_data[47:32];
  a_mode_range: assert property (tw && md > 8'h04 |=> wr_err_r)
    else $error("mode out of range kept");
  a_tconst_range: assert property (tw && tc > 16'hFDE8 |=> wr_err_r)
    else $error("time constant out of range kept");
  a_good_write: assert property (tw && md <= 8'h04 && tc <= 16'hFDE8 |=> !wr_err_r)
    else $error("valid record refused");
  a_bad_index: assert property (wr_en && wr_index > 8'h57 |=> wr_err_r)
    else $error("unmapped write kept");
  a_read_hit: assert property (rd_en && rd_index[7:3] == 5'h0A |=> rd_ok_r)
    else $error("mapped read missed");
  a_read_miss: assert property (rd_en && rd_index > 8'h57 |=> !rd_ok_r)
    else $error("unmapped read hit");
  a_drive_gate: assert property ((sw_out_r & ~sw_drive_r) == 4'h0)
    else $error("undriven pin active");
  a_invert_pin: assert property (pw |-> ##3 sw_out_r[0] != tm_state_r[0])
    else $error("inverted pin not inverted");
endmodule

// >>> testbench/ctrl_input_model.sv
module ctrl_input_model (
  input wire logic ref_clk, // Clock
  input wire logic [3:0] pin, // Sensed pins
  output int rises // Activations seen on pin 2
);
  logic last_r = 1'b0;
  initial rises = 0;
  always @(posedge ref_clk) begin
    if (pin[0] && !last_r) rises <= rises + 1;
    last_r <= pin[0];
  end
endmodule

// >>> testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] area_state = 32'h0;
  logic [7:0] wr_index = 8'h00;
  logic [7:0] rd_index = 8'h00;
  logic [55:0] wr_data = 56'h0;
  logic [55:0] rd_data_r;
  logic rd_ok_r;
  logic wr_err_r;
  logic [3:0] sw_out_r;
  logic [3:0] sw_drive_r;
  logic [3:0] tm_state_r;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int rises;
  // Tick of 5 cycles keeps a 2 ms constant at 10 cycles
  switching_output_time_module #(.TICK_CYCLES(5)) dut (.ref_clk, .rst, .area_state, .wr_en,
    .wr_index, .wr_data, .rd_en, .rd_index, .rd_data_r, .rd_ok_r, .wr_err_r, .sw_out_r,
    .sw_drive_r, .tm_state_r);
  ctrl_input_model plc (.ref_clk, .pin(sw_out_r), .rises);
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string what, logic [55:0] exp, logic [55:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic wr(logic [7:0] idx, logic [55:0] d, logic err);
    wr_index = idx;
    wr_data = d;
    wr_en = 1'b1;
    step(1);
    chk("refusal", {55'h0, err}, {55'h0, wr_err_r});
    wr_en = 1'b0;
    step(1);
  endtask
  task automatic rd(logic [7:0] idx, logic [55:0] d, logic ok);
    rd_index = idx;
    rd_en = 1'b1;
    step(1);
    chk("read data", d, rd_data_r);
    chk("read hit", {55'h0, ok}, {55'h0, rd_ok_r});
    rd_en = 1'b0;
    step(1);
  endtask
  task automatic t_defaults();
    rd(8'h54, 56'h00_0000_0000_0001, 1'b1);
    rd(8'h57, 56'h00_0008_0000_0001, 1'b1);
    rd(8'h58, 56'h0, 1'b0);
    chk("drive", 56'h0, {52'h0, sw_drive_r});
    $display("test defaults done");
  endtask
  task automatic t_refuse();
    wr(8'h54, 56'h05_0000_0000_0001, 1'b1);
    wr(8'h54, 56'h00_FDE9_0000_0001, 1'b1);
    wr(8'h54, 56'h04_FDE8_0000_0001, 1'b0);
    rd(8'h54, 56'h04_FDE8_0000_0001, 1'b1);
    wr(8'h5A, 56'h0, 1'b1);
    wr(8'h50, 56'h00_0000_0200_0001, 1'b1);
    $display("test refuse done");
  endtask
  // Unselected areas stay active throughout, so only mask bit 5 may count
  task automatic t_run(logic [7:0] m, int h, int p1, logic e1, int p2, logic e2);
    int r0;
    wr(8'h54, {m, 16'h0002, 32'h0000_0020}, 1'b0);
    r0 = rises;
    for (int k = 0; k <= p2; k++) begin
      area_state = (k < h) ? 32'hFFFF_FFFF : 32'hFFFF_FFDF;
      step(1);
      if (k == p1) chk("early level", {55'h0, e1}, {55'h0, sw_out_r[0]});
      if (k == p2) chk("late level", {55'h0, e2}, {55'h0, sw_out_r[0]});
    end
    // Return the selected area to idle so the next run starts from rest
    area_state = 32'hFFFF_FFDF;
    step(40);
    chk("activations", {55'h0, e1 | e2}, 56'(rises - r0));
  endtask
  task automatic t_modes();
    wr(8'h50, 56'h1, 1'b0);
    area_state = 32'hFFFF_FFDF;
    t_run(8'h00, 30, 3, 1'b1, 33, 1'b0);
    t_run(8'h01, 30, 5, 1'b0, 20, 1'b1);
    t_run(8'h04, 30, 5, 1'b0, 20, 1'b1);
    t_run(8'h02, 30, 33, 1'b1, 50, 1'b0);
    t_run(8'h03, 1, 4, 1'b1, 30, 1'b0);
    t_run(8'h04, 1, 3, 1'b0, 20, 1'b0);
    $display("test modes done");
  endtask
  task automatic t_pins();
    wr(8'h50, 56'h1_0001, 1'b0);
    step(2);
    chk("inverted", 56'h1, {52'h0, sw_out_r});
    wr(8'h50, 56'h2, 1'b0);
    step(2);
    chk("warning pin", 56'h0, {52'h0, sw_drive_r | sw_out_r});
    wr(8'h53, 56'h1, 1'b0);
    area_state = 32'h1;
    step(3);
    chk("pin 7 only", 56'h8, {52'h0, sw_out_r});
    chk("raw results", 56'hE, {52'h0, tm_state_r});
    rd(8'h53, 56'h1, 1'b1);
    $display("test pins done");
  endtask
  initial begin
    step(16);
    rst = 1'b0;
    t_defaults();
    t_refuse();
    t_modes();
    t_pins();
    report_and_stop();
  end
endmodule
bind switching_output_time_module sw_time_chk chk (.ref_clk, .rst, .wr_en, .wr_index,
  .wr_data, .rd_en, .rd_index, .rd_ok_r, .wr_err_r, .sw_out_r, .sw_drive_r, .tm_state_r);
